// file: ntxpc_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ntxpc_chk #(
    parameter int TICKCYC = 100
)(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Register bus
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic        waitrequest,
    // Events
    input wire logic        rxEnd,
    input wire logic        rxDisturbRestart,
    input wire logic        fieldOn,
    input wire logic        txDataAvail,
    input wire logic        prevActive,
    input wire logic        overshootActive,
    input wire logic [7:0]  gainValue,
    // Outputs
    input wire logic        txStart,
    input wire logic [2:0]  txDriverClockMode,
    input wire logic [4:0]  residualCarrier,
    input wire logic        residualEnable,
    input wire logic [3:0]  gear
);
    logic [15:0] gVal;
    logic [23:0] cnt;
    logic        rfOn, multi, pend, fPrev;
    logic [2:0]  pMode;
    logic [4:0]  pRes;
    logic [7:0]  tMin, tMax;
    wire         wrOk = write && !waitrequest;
    wire         gStart = (rxEnd && !rxDisturbRestart && !multi) || (fieldOn && !fPrev && rfOn);

    always_ff @(posedge clk)
    begin
        fPrev <= fieldOn;
        if (srst)
        begin
            gVal <= 16'h0000;
            {rfOn, multi, pend} <= 3'h0;
            cnt <= 24'h000000;
            pMode <= 3'h7;
            pRes <= 5'h00;
            {tMin, tMax} <= 16'h0000;
        end
        else
        begin
            if (wrOk && address == 4'h0)
                pMode <= writedata[6:4];
            if (wrOk && address == 4'h1)
                pRes <= writedata[12:8];
            if (wrOk && address == 4'h2)
                {multi, rfOn, gVal} <= writedata[17:0];
            if (wrOk && address == 4'h5)
                {tMax, tMin} <= {writedata[23:16], writedata[7:0]};
            if (wrOk && address == 4'h3 && writedata[0])
                pend <= 1'b1;
            else if (txStart)
                pend <= 1'b0;
            if (gStart && gVal != 16'h0000)
                cnt <= 24'(gVal * TICKCYC);
            else if (cnt != 24'h000000)
                cnt <= cnt - 24'h000001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence reqFirst;
        (read || write) && !$past(read || write);
    endsequence
    sequence guardLast;
        cnt == 24'h000001 && pend && txDataAvail;
    endsequence

    bus_wait_a: assert property (reqFirst |-> waitrequest ##1 !waitrequest)
        else $error("bus wait wrong");
    fw_start_a: assert property (txStart |-> pend)
        else $error("tx without send");
    guard_hold_a: assert property (txStart |-> cnt == 24'h000000)
        else $error("tx in guard");
    guard_expire_a: assert property (guardLast |-> ##[1:3] txStart)
        else $error("tx missed expiry");
    resid_en_a: assert property (residualEnable == (txDriverClockMode == 3'h7))
        else $error("resid enable wrong");
    prev_mode_a: assert property ($past(prevActive)
        |-> txDriverClockMode == $past(pMode)) else $error("prev mode missing");
    prev_resid_a: assert property ($past(overshootActive)
        |-> residualCarrier == $past(pRes)) else $error("prev resid missing");
    gear_up_a: assert property (gear > $past(gear) |-> $past(gainValue) > tMax)
        else $error("gear up, low gain");
    gear_down_a: assert property (gear < $past(gear) |-> $past(gainValue) < tMin)
        else $error("gear down, high gain");
    gear_cap_a: assert property (gear <= 4'he)
        else $error("gear too high");
endmodule // ntxpc_chk

bind ntxpc_top ntxpc_chk #(.TICKCYC(TICKCYC)) chk_u (.clk(clk), .srst(srst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .waitrequest(waitrequest), .rxEnd(rxEnd), .rxDisturbRestart(rxDisturbRestart),
    .fieldOn(fieldOn), .txDataAvail(txDataAvail), .prevActive(prevActive),
    .overshootActive(overshootActive), .gainValue(gainValue), .txStart(txStart),
    .txDriverClockMode(txDriverClockMode), .residualCarrier(residualCarrier),
    .residualEnable(residualEnable), .gear(gear));
`default_nettype wire

// file: ntxpc_defs.vh
`ifndef NTXPC_DEFS_VH
`define NTXPC_DEFS_VH

// ****************************************************************
// Register word addresses (word index, not byte offset)
// ****************************************************************
`define NTXPC_ADDR_TXCLK      4'h0
`define NTXPC_ADDR_TXCTRL     4'h1
`define NTXPC_ADDR_GUARD      4'h2
`define NTXPC_ADDR_CMD        4'h3
`define NTXPC_ADDR_DPCCFG     4'h4
`define NTXPC_ADDR_DPCTHR     4'h5
`define NTXPC_ADDR_STATUS     4'h6
`define NTXPC_ADDR_GEARTAB    4'h8

// ****************************************************************
// Clock control fields
// ****************************************************************
`define NTXPC_CLKMODE_LSB     0
`define NTXPC_PREVMODE_LSB    4
`define NTXPC_CLKMODE_ASK10   3'h7

// ****************************************************************
// Transmit control fields
// ****************************************************************
`define NTXPC_RESID_LSB       0
`define NTXPC_PREVRESID_LSB   8
`define NTXPC_RESID_MAX       5'h1f

// ****************************************************************
// Guard control fields
// ****************************************************************
`define NTXPC_GUARD_LSB       0
`define NTXPC_RFONEN_BIT      16
`define NTXPC_MULTIRX_BIT     17
`define NTXPC_MILLER_BIT      18

// ****************************************************************
// Command bits
// ****************************************************************
`define NTXPC_CMD_SEND_BIT    0
`define NTXPC_CMD_DPCEN_BIT   1

// ****************************************************************
// Power control fields
// ****************************************************************
`define NTXPC_INTV_LSB        0
`define NTXPC_NGEAR_LSB       8
`define NTXPC_MINTHR_LSB      0
`define NTXPC_MAXTHR_LSB      16

// ****************************************************************
// Timing: guard tick is 1 us
// ****************************************************************
`define NTXPC_CLK_MHZ         100
`define NTXPC_GUARD_TICK_NS   1000
`define NTXPC_GUARD_TICK_CYC  (`NTXPC_GUARD_TICK_NS * `NTXPC_CLK_MHZ / 1000)

// ****************************************************************
// Reset values
// ****************************************************************
`define NTXPC_RST_TXCLK       32'h00000077
`define NTXPC_RST_TXCTRL      32'h00000000
`define NTXPC_RST_GUARD       32'h00000000
`define NTXPC_RST_DPCCFG      32'h00000f10
`define NTXPC_RST_DPCTHR      32'h0c000400

`endif

// file: ntxpc_gear_mem.v
`timescale 1ns/1ps
`default_nettype none

module ntxpc_gear_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
)(
    // Clock
    input  wire             clk,
    // Write port
    input  wire             wrEn,
    input  wire [AW-1:0]    wrAddr,
    input  wire [WIDTH-1:0] wrData,
    // Read port
    input  wire [AW-1:0]    rdAddr,
    output reg  [WIDTH-1:0] rdData
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule // ntxpc_gear_mem
`default_nettype wire

// file: ntxpc_guard_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "ntxpc_defs.vh"

module ntxpc_guard_timer #(
    parameter WIDTH   = 16,
    parameter TICKCYC = `NTXPC_GUARD_TICK_CYC
)(
    // Clock and reset
    input  wire             clk,
    input  wire             srst,
    // Control
    input  wire             start,
    input  wire [WIDTH-1:0] load,
    // Status
    output reg              running,
    output reg              expire
);

    reg  [15:0]      tickCnt;
    reg  [WIDTH-1:0] count;
    wire             tick;

    assign tick = (tickCnt == 16'h0000);

    always @(posedge clk)
    begin
        if (srst)
        begin
            tickCnt <= 16'h0000;
            count   <= {WIDTH{1'b0}};
            running <= 1'b0;
            expire  <= 1'b0;
        end
        else
        begin
            expire <= 1'b0;
            if (start && (load != {WIDTH{1'b0}}))
            begin
                // Restart on every new start condition with a nonzero load
                count   <= load;
                running <= 1'b1;
                tickCnt <= TICKCYC[15:0] - 16'h0001;
            end
            else if (running)
            begin
                tickCnt <= tick ? (TICKCYC[15:0] - 16'h0001) : (tickCnt - 16'h0001);
                if (tick)
                begin
                    if (count == {{(WIDTH-1){1'b0}}, 1'b1})
                    begin
                        running <= 1'b0;
                        expire  <= 1'b1;
                    end
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // ntxpc_guard_timer
`default_nettype wire

// file: ntxpc_rf_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ntxpc_rf_peer (
    // Clock
    input  wire logic       clk,
    // Receiver and field events
    output var  logic       rxEnd,
    output var  logic       rxDisturbRestart,
    output var  logic       fieldOn,
    output var  logic       bitGrid,
    // Antenna load
    output var  logic [7:0] gainValue
);
    logic [2:0] gridCnt = 3'h0;

    initial
    begin
        {rxEnd, rxDisturbRestart, fieldOn, bitGrid} = 4'h0;
        gainValue = 8'h50;
    end

    // Grid pulse every 8 cycles
    always @(posedge clk)
    begin
        gridCnt <= gridCnt + 3'h1;
        bitGrid <= (gridCnt == 3'h7);
    end

    task automatic endRx(input logic restart);
        @(posedge clk);
        rxEnd <= 1'b1;
        rxDisturbRestart <= restart;
        @(posedge clk);
        rxEnd <= 1'b0;
        rxDisturbRestart <= 1'b0;
    endtask

    task automatic fieldUp;
        @(posedge clk);
        fieldOn <= 1'b0;
        @(posedge clk);
        fieldOn <= 1'b1;
    endtask

    task automatic setGain(input logic [7:0] g);
        @(posedge clk);
        gainValue <= g;
    endtask
endmodule // ntxpc_rf_peer
`default_nettype wire

// file: ntxpc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
    logic [3:0]  address = 4'h0, byteenable = 4'hf;
    logic [31:0] writedata = 32'h0, readdata;
    logic        txDataAvail = 1'b0, prevActive = 1'b0, overshootActive = 1'b0;
    logic        waitrequest, txStart, residualEnable, gridPrev;
    logic [1:0]  response;
    logic [2:0]  txDriverClockMode;
    logic [4:0]  residualCarrier;
    logic [3:0]  supplyConfig, waveShapeOffset, gear;
    logic        rxEnd, rxDisturbRestart, fieldOn, bitGrid;
    logic [7:0]  gainValue;
    int          badCount = 0, nChecks = 0;

    always #5 clk = ~clk;
    always @(posedge clk) gridPrev <= bitGrid;

    ntxpc_top #(.TICKCYC(2), .INTVCYC(4)) dut_u (.clk(clk), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .response(response), .rxEnd(rxEnd),
        .rxDisturbRestart(rxDisturbRestart), .fieldOn(fieldOn), .txDataAvail(txDataAvail),
        .bitGrid(bitGrid), .prevActive(prevActive), .overshootActive(overshootActive),
        .gainValue(gainValue), .txStart(txStart), .txDriverClockMode(txDriverClockMode),
        .residualCarrier(residualCarrier), .residualEnable(residualEnable),
        .supplyConfig(supplyConfig), .waveShapeOffset(waveShapeOffset), .gear(gear));
    ntxpc_rf_peer peer_u (.clk(clk), .rxEnd(rxEnd), .rxDisturbRestart(rxDisturbRestart),
        .fieldOn(fieldOn), .bitGrid(bitGrid), .gainValue(gainValue));

    task automatic endSim;
        $display("Checks %0d bad %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic busWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(negedge clk); while (waitrequest !== 1'b0);
        @(posedge clk);
        write <= 1'b0;
    endtask

    task automatic readCheck(input string what, input logic [3:0] a, input logic [31:0] exp,
                             input logic [1:0] expResp);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        do @(negedge clk); while (waitrequest !== 1'b0);
        @(posedge clk);
        check(what, readdata, exp);
        check({what, " rsp"}, response, 32'(expResp));
        read <= 1'b0;
    endtask

    task automatic waitTx(output int n);
        for (n = 0; txStart !== 1'b1 && n < 300; n++)
            @(negedge clk);
        check("tx", n < 300, 1);
    endtask

    logic [3:0]  rAdr [5] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h7};
    logic [31:0] rVal [5] = '{32'h77, 32'h0, 32'hf10, 32'h0c000400, 32'h0};
    logic [1:0]  rRsp [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    logic [31:0] gCfg [6] = '{32'h14, 32'h20014, 32'h14, 32'h10014, 32'h14, 32'h0};
    logic [1:0]  gEv  [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
    logic        gDly [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

    initial
    begin
        int n;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        txDataAvail <= 1'b1;
        for (int i = 0; i < 5; i++)
            readCheck("reset", rAdr[i], rVal[i], rRsp[i]);
        // Guard sources
        for (int i = 0; i < 6; i++)
        begin
            busWrite(4'h2, gCfg[i]);
            if (gEv[i] == 2'h2)
                peer_u.fieldUp();
            else
                peer_u.endRx(gEv[i][0]);
            busWrite(4'h3, 32'h1);
            waitTx(n);
            check("guard", n > 20, gDly[i]);
            repeat (60) @(posedge clk);
        end
        busWrite(4'h2, 32'h40000);
        busWrite(4'h3, 32'h1);
        waitTx(n);
        check("grid", gridPrev, 1);
        // Prevention overrides
        busWrite(4'h0, 32'h57);
        busWrite(4'h1, 32'h1f0a);
        readCheck("txctl", 4'h1, 32'h1f0a, 2'h0);
        repeat (3) @(posedge clk);
        check("clock mode", txDriverClockMode, 3'h7);
        check("resid", residualCarrier, 5'h0a);
        check("resid en", residualEnable, 1);
        prevActive <= 1'b1;
        overshootActive <= 1'b1;
        repeat (4) @(posedge clk);
        check("prev mode", txDriverClockMode, 3'h5);
        check("prev resid", residualCarrier, 5'h1f);
        prevActive <= 1'b0;
        overshootActive <= 1'b0;
        busWrite(4'h0, 32'h56);
        repeat (3) @(posedge clk);
        check("resid off", residualEnable, 0);
        // Power gears
        for (int g = 0; g < 4; g++)
            busWrite(4'(8 + g), 32'h81 + 32'(g) * 32'h11);
        busWrite(4'h4, 32'h400);
        busWrite(4'h5, 32'h800020);
        peer_u.setGain(8'hc0);
        repeat (30) @(posedge clk);
        check("gear idle", gear, 4'h0);
        busWrite(4'h3, 32'h2);
        repeat (60) @(posedge clk);
        check("gear top", gear, 4'h3);
        check("supply top", supplyConfig, 4'h4);
        check("wave top", waveShapeOffset, 4'hb);
        readCheck("status", 4'h6, 32'h3c000, 2'h0);
        peer_u.setGain(8'h10);
        repeat (60) @(posedge clk);
        check("gear bottom", gear, 4'h0);
        check("supply bottom", supplyConfig, 4'h1);
        check("wave bottom", waveShapeOffset, 4'h8);
        peer_u.setGain(8'h50);
        repeat (30) @(posedge clk);
        check("gear hold", gear, 4'h0);
        endSim();
    end

    initial
    begin
        #100000;
        badCount++;
        endSim();
    end
endmodule // tb_top
`default_nettype wire

// file: ntxpc_top.v
// Summary of operation
// - Residual carrier code 0..31, full carrier at 0, none at 31.
// - Residual carrier applies only with clock mode 3'b111.
// - Guard timer starts at a reception end, good or bad, except as below.
// - No guard start on disturbance restart or multiple reception enabled.
// - With guard-on-field enable, field switch-on also starts guard timer.
// - Guard value zero disables the guard time.
// - Running guard holds off transmission even with send-start set.
// - Data ready and send-start before expiry: transmit exactly at expiry.
// - Send-start late with Miller sync enabled: start on bit grid.
// - Prevention active selects prevention clock mode.
// - Overshoot pattern active selects prevention residual carrier.
// - Gain value sampled periodically, interval from configuration byte.
// - Each sample compared with maximum and minimum thresholds.
// - Threshold exceeded selects another gear and supply voltage.
// - Up to fifteen gears, count set by application; only gears 0..7 have table entries.
// - Gear also selects wave-shaping offset.
`timescale 1ns/1ps
`default_nettype none
`include "ntxpc_defs.vh"

module ntxpc_top #(
    parameter GUARDW  = 16,
    parameter TICKCYC = `NTXPC_GUARD_TICK_CYC,
    parameter INTVCYC = 1000
)(
    // Clock and reset
    input  wire        clk,
    input  wire        srst,
    // Avalon-MM slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    output reg  [1:0]  response,
    // Receiver and field events
    input  wire        rxEnd,
    input  wire        rxDisturbRestart,
    input  wire        fieldOn,
    input  wire        txDataAvail,
    input  wire        bitGrid,
    // Over and undershoot prevention
    input  wire        prevActive,
    input  wire        overshootActive,
    // Gain measurement
    input  wire [7:0]  gainValue,
    // Transmitter outputs
    output reg         txStart,
    output reg  [2:0]  txDriverClockMode,
    output reg  [4:0]  residualCarrier,
    output reg         residualEnable,
    output reg  [3:0]  supplyConfig,
    output reg  [3:0]  waveShapeOffset,
    output reg  [3:0]  gear
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [31:0] txClockControlRegister;
    reg  [31:0] txControlRegister;
    reg  [31:0] guardCfg;
    reg  [31:0] dpcCfg;
    reg  [31:0] dpcThr;
    reg         sendPending;
    reg         dpcEnable;
    reg         ackPhase;
    reg  [7:0]  lastGain;
    reg         fieldOnD;

    wire        guardRunning;
    wire        guardExpire;
    wire        guardStart;
    wire [15:0] gearRd;
    wire        busReq;
    wire        wrHit;
    wire        tabWr;

    wire [2:0]  clkModeNormal = txClockControlRegister[`NTXPC_CLKMODE_LSB +: 3];
    wire [2:0]  clkModePrev   = txClockControlRegister[`NTXPC_PREVMODE_LSB +: 3];
    wire [4:0]  residNormal   = txControlRegister[`NTXPC_RESID_LSB +: 5];
    wire [4:0]  residPrev     = txControlRegister[`NTXPC_PREVRESID_LSB +: 5];
    wire [15:0] guardVal      = guardCfg[`NTXPC_GUARD_LSB +: 16];
    wire        guardOnFieldEnable = guardCfg[`NTXPC_RFONEN_BIT];
    wire        multiRxEnable = guardCfg[`NTXPC_MULTIRX_BIT];
    wire        millerSync    = guardCfg[`NTXPC_MILLER_BIT];
    wire [7:0]  measurementIntervalByte = dpcCfg[`NTXPC_INTV_LSB +: 8];
    wire [3:0]  gearCount     = dpcCfg[`NTXPC_NGEAR_LSB +: 4];
    wire [7:0]  minThr        = dpcThr[`NTXPC_MINTHR_LSB +: 8];
    wire [7:0]  maxThr        = dpcThr[`NTXPC_MAXTHR_LSB +: 8];

    // Byte-lane merge of a write into an old word
    function [31:0] laneMerge;
        input [31:0] old;
        input [31:0] din;
        input [3:0]  be;
        integer      i;
        begin
            laneMerge = old;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (be[i])
                begin
                    laneMerge[i*8 +: 8] = din[i*8 +: 8];
                end
            end
        end
    endfunction

    // ****************************************************************
    // Avalon slave: one wait cycle, answer on second cycle
    // ****************************************************************
    assign busReq      = read | write;
    assign waitrequest = busReq & ~ackPhase;
    assign wrHit       = write & ackPhase;
    assign tabWr       = wrHit & address[3];

    always @(posedge clk)
    begin
        if (srst)
        begin
            ackPhase <= 1'b0;
        end
        else
        begin
            ackPhase <= busReq & ~ackPhase;
        end
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            txClockControlRegister <= `NTXPC_RST_TXCLK;
            txControlRegister      <= `NTXPC_RST_TXCTRL;
            guardCfg               <= `NTXPC_RST_GUARD;
            dpcCfg                 <= `NTXPC_RST_DPCCFG;
            dpcThr                 <= `NTXPC_RST_DPCTHR;
            dpcEnable              <= 1'b0;
        end
        else if (wrHit && !address[3])
        begin
            case (address)
                `NTXPC_ADDR_TXCLK:
                    txClockControlRegister <= laneMerge(txClockControlRegister,
                                                        writedata, byteenable);
                `NTXPC_ADDR_TXCTRL:
                    txControlRegister <= laneMerge(txControlRegister, writedata, byteenable);
                `NTXPC_ADDR_GUARD:
                    guardCfg <= laneMerge(guardCfg, writedata, byteenable);
                `NTXPC_ADDR_CMD:
                    if (byteenable[0])
                    begin
                        dpcEnable <= writedata[`NTXPC_CMD_DPCEN_BIT];
                    end
                `NTXPC_ADDR_DPCCFG:
                    dpcCfg <= laneMerge(dpcCfg, writedata, byteenable);
                `NTXPC_ADDR_DPCTHR:
                    dpcThr <= laneMerge(dpcThr, writedata, byteenable);
                default:
                    dpcEnable <= dpcEnable;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            readdata <= 32'h00000000;
            response <= 2'h0;
        end
        else if (read && !ackPhase)
        begin
            response <= 2'h0;
            if (address[3])
            begin
                readdata <= 32'h00000000;
            end
            else
            begin
                case (address)
                    `NTXPC_ADDR_TXCLK:  readdata <= txClockControlRegister;
                    `NTXPC_ADDR_TXCTRL: readdata <= txControlRegister;
                    `NTXPC_ADDR_GUARD:  readdata <= guardCfg;
                    `NTXPC_ADDR_CMD:    readdata <= {30'h00000000, dpcEnable, sendPending};
                    `NTXPC_ADDR_DPCCFG: readdata <= dpcCfg;
                    `NTXPC_ADDR_DPCTHR: readdata <= dpcThr;
                    `NTXPC_ADDR_STATUS: readdata <= {12'h000, gear, lastGain,
                                                     6'h00, guardRunning, sendPending};
                    default:
                    begin
                        readdata <= 32'h00000000;
                        response <= 2'h2;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Guard time
    // ****************************************************************
    always @(posedge clk)
    begin
        if (srst)
        begin
            fieldOnD <= 1'b0;
        end
        else
        begin
            fieldOnD <= fieldOn;
        end
    end

    assign guardStart = (rxEnd & ~rxDisturbRestart & ~multiRxEnable)
                      | (guardOnFieldEnable & fieldOn & ~fieldOnD);

    ntxpc_guard_timer #(
        .WIDTH   (GUARDW),
        .TICKCYC (TICKCYC)
    ) uGuard (
        .clk     (clk),
        .srst    (srst),
        .start   (guardStart),
        .load    (guardVal[GUARDW-1:0]),
        .running (guardRunning),
        .expire  (guardExpire)
    );

    // ****************************************************************
    // Transmission start
    // ****************************************************************
    always @(posedge clk)
    begin
        if (srst)
        begin
            sendPending <= 1'b0;
            txStart     <= 1'b0;
        end
        else
        begin
            txStart <= 1'b0;
            if (sendPending && txDataAvail && !guardRunning && !guardStart)
            begin
                if (guardExpire)
                begin
                    txStart     <= 1'b1;
                    sendPending <= 1'b0;
                end
                else if (!millerSync || bitGrid)
                begin
                    txStart     <= 1'b1;
                    sendPending <= 1'b0;
                end
            end
            // Only firmware arms a send; new request wins
            if (wrHit && address == `NTXPC_ADDR_CMD && byteenable[0]
                && writedata[`NTXPC_CMD_SEND_BIT])
            begin
                sendPending <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Clock mode and residual carrier
    // ****************************************************************
    always @(posedge clk)
    begin
        if (srst)
        begin
            txDriverClockMode <= 3'h7;
            residualCarrier   <= 5'h00;
            residualEnable    <= 1'b1;
        end
        else
        begin
            txDriverClockMode <= prevActive ? clkModePrev : clkModeNormal;
            residualCarrier   <= overshootActive ? residPrev : residNormal;
            residualEnable    <= ((prevActive ? clkModePrev : clkModeNormal)
                                  == `NTXPC_CLKMODE_ASK10);
        end
    end

    // ****************************************************************
    // Dynamic power control
    // ****************************************************************
    reg  [15:0] intvPre;
    reg  [7:0]  intvCnt;
    reg         sampleNow;
    wire [3:0]  lastGear = gearCount - 4'h1;

    always @(posedge clk)
    begin
        if (srst)
        begin
            intvPre   <= 16'h0000;
            intvCnt   <= 8'h00;
            sampleNow <= 1'b0;
        end
        else
        begin
            sampleNow <= 1'b0;
            if (!dpcEnable)
            begin
                intvPre <= 16'h0000;
                intvCnt <= 8'h00;
            end
            else if (intvPre == INTVCYC[15:0] - 16'h0001)
            begin
                intvPre <= 16'h0000;
                if (intvCnt >= measurementIntervalByte)
                begin
                    intvCnt   <= 8'h00;
                    sampleNow <= 1'b1;
                end
                else
                begin
                    intvCnt <= intvCnt + 8'h01;
                end
            end
            else
            begin
                intvPre <= intvPre + 16'h0001;
            end
        end
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            gear     <= 4'h0;
            lastGain <= 8'h00;
        end
        else if (sampleNow)
        begin
            lastGain <= gainValue;
            if (gainValue > maxThr && gear < lastGear && gear < 4'he)
            begin
                gear <= gear + 4'h1;
            end
            else if (gainValue < minThr && gear != 4'h0)
            begin
                gear <= gear - 4'h1;
            end
        end
    end

    ntxpc_gear_mem #(
        .WIDTH (16),
        .DEPTH (16),
        .AW    (4)
    ) uGearTab (
        .clk    (clk),
        .wrEn   (tabWr),
        .wrAddr ({1'b0, address[2:0]}),
        .wrData (writedata[15:0]),
        .rdAddr (gear),
        .rdData (gearRd)
    );

    always @(posedge clk)
    begin
        if (srst)
        begin
            supplyConfig    <= 4'h0;
            waveShapeOffset <= 4'h0;
        end
        else
        begin
            supplyConfig    <= gearRd[3:0];
            waveShapeOffset <= gearRd[7:4];
        end
    end

endmodule // ntxpc_top
`default_nettype wire
